// ==== scpi_params.svh ====
// scpi_params.svh: character codes, tree node ids and sizes for the parser
// assumes: 8-bit ASCII characters, one per clock when valid
`ifndef SCPI_PARAMS_SVH
`define SCPI_PARAMS_SVH
`define CH_NL       8'h0A
`define CH_SPACE    8'h20
`define CH_STAR     8'h2A
`define CH_COLON    8'h3A
`define CH_SEMI     8'h3B
`define CH_QUERY    8'h3F
`define CH_DIG_LO   8'h30
`define CH_DIG_HI   8'h39
`define CH_UP_LO    8'h41
`define CH_UP_HI    8'h5A
`define CH_LOW_LO   8'h61
`define CH_LOW_HI   8'h7A
`define CASE_BIT    8'h20
`define KEY_LEN     12
`define KEY_LEN_W   4
`define NODE_W      5
`define NODE_ROOT   5'h00
`define NODE_SOURCE 5'h08
`define NODE_COUNT  29
`define SHORT_ALL   4
`define SHORT_VOW   3
`define SHORT_CONS  4
`define VOWEL_POS   4
`endif

// ==== scpi_pkg.sv ====
// scpi_pkg: types shared by the parser and the keyword matcher
// assumes: scpi_params.svh on the include path
`include "scpi_params.svh"
package scpi_pkg;
    typedef logic [`NODE_W-1:0] node_type;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_COLON,
        ST_KEY,
        ST_QUERY,
        ST_DATA,
        ST_COMMON,
        ST_SKIP
    } state_type;
endpackage

// ==== keyword_matcher.sv ====
// keyword_matcher: looks up one upper-cased keyword in the command tree
// assumes: word right-aligned with zero fill above its length
`timescale 1ns/1ps
`include "scpi_params.svh"
module keyword_matcher (
    input  wire logic [8*`KEY_LEN-1:0]  word,  // keyword, last char in low byte
    input  wire logic [`KEY_LEN_W-1:0]  len,   // keyword length in chars
    input  wire scpi_pkg::node_type     node,  // current tree position
    output logic                        hit,   // keyword valid here
    output scpi_pkg::node_type          id     // node id of the keyword
);
    localparam int KW = 8 * `KEY_LEN;

    // tree table: parent id and long form
    function automatic logic [`NODE_W+KW-1:0] entry(input int i);
        case (i)
            1:  entry = {`NODE_ROOT, KW'("ABORT")};
            2:  entry = {`NODE_ROOT, KW'("CALIBRATE")};
            3:  entry = {`NODE_ROOT, KW'("DISPLAY")};
            4:  entry = {`NODE_ROOT, KW'("INITIATE")};
            5:  entry = {`NODE_ROOT, KW'("LIST")};
            6:  entry = {`NODE_ROOT, KW'("MEASURE")};
            7:  entry = {`NODE_ROOT, KW'("OUTPUT")};
            8:  entry = {`NODE_ROOT, KW'("SOURCE")};
            9:  entry = {`NODE_ROOT, KW'("STATUS")};
            10: entry = {`NODE_ROOT, KW'("SYSTEM")};
            11: entry = {`NODE_ROOT, KW'("TRIGGER")};
            12: entry = {`NODE_SOURCE, KW'("VOLTAGE")};
            13: entry = {`NODE_SOURCE, KW'("CURRENT")};
            14: entry = {`NODE_SOURCE, KW'("FUNCTION")};
            15: entry = {5'h09, KW'("OPERATION")};
            16: entry = {5'h09, KW'("PRESET")};
            17: entry = {5'h09, KW'("QUESTIONABLE")};
            18: entry = {5'h0F, KW'("CONDITION")};
            19: entry = {5'h0F, KW'("ENABLE")};
            20: entry = {5'h0F, KW'("EVENT")};
            21: entry = {5'h0C, KW'("LEVEL")};
            22: entry = {5'h15, KW'("IMMEDIATE")};
            23: entry = {5'h15, KW'("TRIGGER")};
            24: entry = {5'h0E, KW'("MODE")};
            25: entry = {5'h06, KW'("VOLTAGE")};
            26: entry = {5'h06, KW'("CURRENT")};
            27: entry = {5'h0D, KW'("LEVEL")};
            28: entry = {5'h1B, KW'("IMMEDIATE")};
            29: entry = {5'h1B, KW'("TRIGGER")};
            default: entry = '0;
        endcase
    endfunction

    // number of characters in a long form
    function automatic int long_len(input logic [KW-1:0] nm);
        long_len = 0;
        for (int k = 0; k < `KEY_LEN; k++) begin
            if (nm[8*k+:8] != 8'h00) begin
                long_len = k + 1;
            end
        end
    endfunction

    // short form length derived from the long form
    function automatic int short_len(input logic [KW-1:0] nm, input int l);
        logic [7:0] c;
        c = 8'h00;
        if (l <= `SHORT_ALL) begin
            short_len = l;
        end else begin
            c = nm[8*(l-`VOWEL_POS)+:8];
            short_len = (c == "A" || c == "E" || c == "I" || c == "O" || c == "U") ? `SHORT_VOW : `SHORT_CONS; // R4
        end
    endfunction

    // scan table; lowest id wins on a double match
    always_comb begin
        logic [KW-1:0] nm;
        scpi_pkg::node_type par;
        int l;
        int s;
        nm = '0;
        par = `NODE_ROOT;
        l = 0;
        s = 0;
        hit = 1'b0;
        id = `NODE_ROOT;
        for (int i = `NODE_COUNT; i >= 1; i--) begin
            {par, nm} = entry(i);
            l = long_len(nm);
            s = short_len(nm, l);
            if ((par == node || (node == `NODE_ROOT && par == `NODE_SOURCE)) && // R15 R16
                ((int'(len) == l && word == nm) || (int'(len) == s && word == (nm >> (8*(l-s)))))) begin // R5
                hit = 1'b1;
                id = scpi_pkg::node_type'(i);
            end
        end
    end
endmodule

// ==== scpi_message_parser.sv ====
// scpi_message_parser: splits a command character stream into message units
// assumes: one char per ref_clk when rx_valid; input always accepted
`timescale 1ns/1ps
`include "scpi_params.svh"
// Functional notes
// (R1) newline character ends a program message
// (R2) char with end-of-line flag also terminates
// (R3) host terminates messages; end reported on terminator
// (R4) short form: first four, three if vowel
// (R5) only full short or long form accepted
// (R6) keyword compare ignores letter case
// (R7) colon separates adjacent keywords of a command
// (R8) keyword separator descends into named branch
// (R9) question mark after last keyword makes query
// (R10) data follows keyword or query after space
// (R11) semicolon separates message units
// (R12) leading colon resets position to root
// (R13) terminator or root specifier returns to root
// (R14) after semicolon decode sibling of last keyword
// (R15) source children accepted at root level
// (R16) root keywords of the command tree recognised
// (R17) asterisk starts a common command
// (R18) first command of message decoded from root
// (R19) bad unit discarded, error flagged, resume later
module scpi_message_parser (
    input  wire logic                   ref_clk,        // 20 MHz clock
    input  wire logic                   rst_n,          // sync reset, low
    input  wire logic                   rx_valid,       // character present
    input  wire logic [7:0]             rx_data,        // character code
    input  wire logic                   rx_eol,         // end-of-line flag
    output logic                        unit_valid,     // unit complete pulse
    output logic                        unit_query,     // unit is a query
    output logic                        unit_common,    // unit is common cmd
    output logic                        unit_has_data,  // unit carried data
    output scpi_pkg::node_type          unit_node,      // last keyword node
    output logic [8*`KEY_LEN-1:0]       unit_word,      // last keyword text
    output logic                        data_valid,     // data char pulse
    output logic [7:0]                  data_char,      // data character
    output logic                        msg_end,        // terminator pulse
    output logic                        cmd_error,      // command error pulse
    output scpi_pkg::node_type          tree_node       // current position
);
    localparam int KW = 8 * `KEY_LEN;

    // fold lower case letters onto upper case
    function automatic logic [7:0] to_upper(input logic [7:0] c);
        to_upper = (c >= `CH_LOW_LO && c <= `CH_LOW_HI) ? (c & ~`CASE_BIT) : c;
    endfunction

    // letter of either case
    function automatic logic is_alpha(input logic [7:0] c);
        is_alpha = (to_upper(c) >= `CH_UP_LO) && (to_upper(c) <= `CH_UP_HI);
    endfunction

    // character allowed inside a keyword
    function automatic logic is_word(input logic [7:0] c);
        is_word = is_alpha(c) || (c >= `CH_DIG_LO && c <= `CH_DIG_HI);
    endfunction

    scpi_pkg::state_type        state;
    scpi_pkg::state_type        next_state;
    scpi_pkg::node_type         cur_node;
    scpi_pkg::node_type         last_node;
    scpi_pkg::node_type         match_id;
    logic [KW-1:0]              word;
    logic [`KEY_LEN_W-1:0]      word_len;
    logic                       key_hit;
    logic                       q_flag;
    logic                       c_flag;
    logic                       d_flag;
    logic                       is_term;
    logic                       start_key;
    logic                       clear_key;
    logic                       grow;
    logic                       go_root;
    logic                       descend;
    logic                       take_key;
    logic                       set_query;
    logic                       set_common;
    logic                       data_out;
    logic                       unit_end;
    logic                       err;

    // keyword lookup at the current tree position
    keyword_matcher u_match (
        .word (word),
        .len  (word_len),
        .node (cur_node),
        .hit  (key_hit),
        .id   (match_id)
    );

    // terminator: newline or any char flagged end-of-line
    assign is_term = rx_valid && (rx_eol || rx_data == `CH_NL); // R1 R2

    // per-character decision
    always_comb begin
        next_state = state;
        start_key = 1'b0;
        clear_key = 1'b0;
        grow = 1'b0;
        go_root = 1'b0;
        descend = 1'b0;
        take_key = 1'b0;
        set_query = 1'b0;
        set_common = 1'b0;
        data_out = 1'b0;
        unit_end = 1'b0;
        err = 1'b0;
        if (is_term) begin
            next_state = scpi_pkg::ST_IDLE;
            go_root = 1'b1; // R13
            unique case (state)
                scpi_pkg::ST_KEY: begin
                    err = !key_hit;
                    unit_end = key_hit;
                    take_key = key_hit;
                end
                scpi_pkg::ST_COLON: err = 1'b1;
                scpi_pkg::ST_QUERY, scpi_pkg::ST_DATA, scpi_pkg::ST_COMMON: unit_end = 1'b1;
                scpi_pkg::ST_IDLE, scpi_pkg::ST_SKIP: err = 1'b0;
            endcase
        end else if (rx_valid) begin
            unique case (state)
                // start of a unit
                scpi_pkg::ST_IDLE: begin
                    if (rx_data == `CH_COLON) begin
                        go_root = 1'b1; // R12
                        next_state = scpi_pkg::ST_COLON;
                    end else if (rx_data == `CH_STAR) begin
                        clear_key = 1'b1;
                        set_common = 1'b1; // R17
                        next_state = scpi_pkg::ST_COMMON;
                    end else if (is_alpha(rx_data)) begin
                        start_key = 1'b1;
                        next_state = scpi_pkg::ST_KEY;
                    end else if (rx_data != `CH_SPACE && rx_data != `CH_SEMI) begin
                        err = 1'b1;
                    end
                end
                // a keyword must follow a colon
                scpi_pkg::ST_COLON: begin
                    if (is_alpha(rx_data)) begin
                        start_key = 1'b1;
                        next_state = scpi_pkg::ST_KEY;
                    end else begin
                        err = 1'b1;
                    end
                end
                // inside a keyword
                scpi_pkg::ST_KEY: begin
                    if (is_word(rx_data)) begin
                        grow = (word_len < `KEY_LEN_W'(`KEY_LEN));
                        err = !grow; // R5
                    end else if (!key_hit) begin
                        err = 1'b1; // R19
                    end else if (rx_data == `CH_COLON) begin
                        descend = 1'b1; // R7 R8
                        take_key = 1'b1;
                        next_state = scpi_pkg::ST_COLON;
                    end else if (rx_data == `CH_QUERY) begin
                        set_query = 1'b1; // R9
                        take_key = 1'b1;
                        next_state = scpi_pkg::ST_QUERY;
                    end else if (rx_data == `CH_SPACE) begin
                        take_key = 1'b1; // R10
                        next_state = scpi_pkg::ST_DATA;
                    end else if (rx_data == `CH_SEMI) begin
                        take_key = 1'b1; // R11 R14
                        unit_end = 1'b1;
                        next_state = scpi_pkg::ST_IDLE;
                    end else begin
                        err = 1'b1;
                    end
                end
                // after the query indicator
                scpi_pkg::ST_QUERY: begin
                    if (rx_data == `CH_SPACE) begin
                        next_state = scpi_pkg::ST_DATA; // R10
                    end else if (rx_data == `CH_SEMI) begin
                        unit_end = 1'b1; // R11
                        next_state = scpi_pkg::ST_IDLE;
                    end else begin
                        err = 1'b1;
                    end
                end
                // data parameter runs to the next separator
                scpi_pkg::ST_DATA: begin
                    if (rx_data == `CH_SEMI) begin
                        unit_end = 1'b1; // R11
                        next_state = scpi_pkg::ST_IDLE;
                    end else begin
                        data_out = 1'b1;
                    end
                end
                // common command word, outside the tree
                scpi_pkg::ST_COMMON: begin
                    if (is_word(rx_data) && word_len < `KEY_LEN_W'(`KEY_LEN)) begin
                        grow = 1'b1;
                    end else if (rx_data == `CH_QUERY) begin
                        set_query = 1'b1;
                    end else if (rx_data == `CH_SPACE) begin
                        next_state = scpi_pkg::ST_DATA;
                    end else if (rx_data == `CH_SEMI) begin
                        unit_end = 1'b1;
                        next_state = scpi_pkg::ST_IDLE;
                    end else begin
                        err = 1'b1;
                    end
                end
                // discard until a unit separator
                scpi_pkg::ST_SKIP: begin
                    if (rx_data == `CH_SEMI) begin
                        next_state = scpi_pkg::ST_IDLE; // R19
                    end
                end
            endcase
            // an error found at a semicolon already sits on the separator
            if (err) begin
                next_state = (rx_data == `CH_SEMI) ? scpi_pkg::ST_IDLE : scpi_pkg::ST_SKIP; // R14 R19
            end
        end
    end

    // parser state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= scpi_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // tree position; root at reset so first unit starts there
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur_node <= `NODE_ROOT; // R18
        end else if (go_root) begin
            cur_node <= `NODE_ROOT; // R12 R13
        end else if (descend) begin
            cur_node <= match_id; // R8
        end
    end

    // keyword buffer, upper-cased, right-aligned
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            word <= '0;
            word_len <= '0;
        end else if (start_key) begin
            word <= KW'(to_upper(rx_data)); // R6
            word_len <= `KEY_LEN_W'(1);
        end else if (clear_key) begin
            word <= '0;
            word_len <= '0;
        end else if (grow) begin
            word <= {word[KW-9:0], to_upper(rx_data)}; // R6
            word_len <= word_len + `KEY_LEN_W'(1);
        end
    end

    // per-unit flags, cleared when the unit closes or fails
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q_flag <= 1'b0;
            c_flag <= 1'b0;
            d_flag <= 1'b0;
            last_node <= `NODE_ROOT;
        end else if (unit_end || err || is_term) begin
            q_flag <= 1'b0;
            c_flag <= 1'b0;
            d_flag <= 1'b0;
        end else begin
            q_flag <= q_flag | set_query;
            c_flag <= c_flag | set_common;
            d_flag <= d_flag | data_out;
            if (take_key) begin
                last_node <= match_id;
            end
        end
    end

    // unit report, one pulse per completed unit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            unit_valid <= 1'b0;
            unit_query <= 1'b0;
            unit_common <= 1'b0;
            unit_has_data <= 1'b0;
            unit_node <= `NODE_ROOT;
            unit_word <= '0;
        end else begin
            unit_valid <= unit_end;
            if (unit_end) begin
                unit_query <= q_flag; // R9
                unit_common <= c_flag; // R17
                unit_has_data <= d_flag;
                unit_node <= take_key ? match_id : last_node;
                unit_word <= word;
            end
        end
    end

    // data characters and message events
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_valid <= 1'b0;
            data_char <= 8'h00;
            msg_end <= 1'b0;
            cmd_error <= 1'b0;
        end else begin
            data_valid <= data_out; // R10
            data_char <= rx_data;
            msg_end <= is_term; // R3
            cmd_error <= err; // R19
        end
    end

    assign tree_node = cur_node;

    // newline is taken as a terminator
    property p_nl_term;
        @(posedge ref_clk) disable iff (!rst_n)
        rx_valid && rx_data == `CH_NL |=> msg_end && tree_node == `NODE_ROOT;
    endproperty
    a_nl_term: assert property (p_nl_term) else $error("newline did not end message"); // R1

    // any char with end-of-line ends the message
    property p_eol_term;
        @(posedge ref_clk) disable iff (!rst_n)
        rx_valid && rx_eol |=> msg_end && state == scpi_pkg::ST_IDLE;
    endproperty
    a_eol_term: assert property (p_eol_term) else $error("eol char did not end message"); // R2

    // leading colon puts the position at root
    property p_root_spec;
        @(posedge ref_clk) disable iff (!rst_n)
        state == scpi_pkg::ST_IDLE && rx_valid && !is_term && rx_data == `CH_COLON
        |=> tree_node == `NODE_ROOT && state == scpi_pkg::ST_COLON;
    endproperty
    a_root_spec: assert property (p_root_spec) else $error("root specifier ignored"); // R12

    // separator after a known keyword descends into it
    property p_descend;
        @(posedge ref_clk) disable iff (!rst_n)
        state == scpi_pkg::ST_KEY && rx_valid && !is_term && rx_data == `CH_COLON && key_hit
        |=> tree_node == $past(match_id);
    endproperty
    a_descend: assert property (p_descend) else $error("separator did not descend"); // R8

    // keyword, question mark, semicolon gives a query unit
    sequence s_query_unit;
        state == scpi_pkg::ST_KEY && rx_valid && !is_term && rx_data == `CH_QUERY && key_hit
        ##1 rx_valid && !is_term && rx_data == `CH_SEMI;
    endsequence
    property p_query;
        @(posedge ref_clk) disable iff (!rst_n)
        s_query_unit |=> unit_valid && unit_query;
    endproperty
    a_query: assert property (p_query) else $error("query not reported"); // R9

    // semicolon keeps the level for the next unit
    property p_sibling;
        @(posedge ref_clk) disable iff (!rst_n)
        state == scpi_pkg::ST_KEY && rx_valid && !is_term && rx_data == `CH_SEMI && key_hit
        |=> unit_valid && tree_node == $past(tree_node) && state == scpi_pkg::ST_IDLE;
    endproperty
    a_sibling: assert property (p_sibling) else $error("semicolon changed level"); // R14

    // unknown keyword flags an error and skips the unit
    property p_bad_key;
        @(posedge ref_clk) disable iff (!rst_n)
        state == scpi_pkg::ST_KEY && rx_valid && !is_term && !is_word(rx_data) && !key_hit
        |=> cmd_error && !unit_valid &&
            state == (($past(rx_data) == `CH_SEMI) ? scpi_pkg::ST_IDLE : scpi_pkg::ST_SKIP);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad keyword not flagged"); // R19

    // asterisk opens a common command unit
    property p_common;
        @(posedge ref_clk) disable iff (!rst_n)
        state == scpi_pkg::ST_IDLE && rx_valid && !is_term && rx_data == `CH_STAR
        |=> state == scpi_pkg::ST_COMMON && tree_node == $past(tree_node);
    endproperty
    a_common: assert property (p_common) else $error("common command not entered"); // R17
endmodule

// ==== scpi_host_model.sv ====
// scpi_host_model: host controller sending command strings, one char per clock
// assumes: the parser takes a char on every rising edge with rx_valid high
`timescale 1ns/1ps
module scpi_host_model (
    input  wire logic       ref_clk,  // parser clock
    output logic            rx_valid, // char present
    output logic [7:0]      rx_data,  // char code
    output logic            rx_eol    // end-of-line flag
);
    // idle bus at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_eol   = 1'b0;
    end
    // send one message; term high ends with newline, low with an eol-flagged char
    task automatic send(input string s, input bit term);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge ref_clk);
            #5;
            rx_valid = 1'b1;
            rx_data  = s[i];
            rx_eol   = 1'b0;
        end
        @(posedge ref_clk);
        #5;
        rx_data = term ? 8'h0A : 8'h7E;
        rx_eol  = !term;
        @(posedge ref_clk);
        #5;
        rx_valid = 1'b0;
        rx_eol   = 1'b0;
        rx_data  = ~rx_data; // released line never shows the stale char
    endtask
endmodule

// ==== tb_scpi_message_parser.sv ====
// tb_scpi_message_parser: self-checking bench for the message parser
// assumes: host model drives chars 5 ns after the rising edge
`timescale 1ns/1ps
module tb_scpi_message_parser;
    logic               ref_clk, rst_n, rx_valid, rx_eol;
    logic [7:0]         rx_data, data_char;
    logic               unit_valid, unit_query, unit_common, unit_has_data;
    logic               data_valid, msg_end, cmd_error, lq, lc, ld;
    scpi_pkg::node_type unit_node, tree_node;
    logic [95:0]        unit_word, lw;
    scpi_pkg::node_type nq[$];
    logic [7:0]         dq[$];
    int                 error_cnt, cmp_count, n_err, n_end;
    string              roots[11] = '{"ABORT", "cal", "DISPlay", "INIT", "list", "MEASURE",
                                      "outp", "SOURCE", "stat", "SYSTEM", "TRIG"};

    scpi_host_model host (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_eol(rx_eol));
    scpi_message_parser dut (.ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_eol(rx_eol), .unit_valid(unit_valid), .unit_query(unit_query), .unit_common(unit_common),
        .unit_has_data(unit_has_data), .unit_node(unit_node), .unit_word(unit_word), .data_valid(data_valid),
        .data_char(data_char), .msg_end(msg_end), .cmd_error(cmd_error), .tree_node(tree_node));

    // clock generator
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // collect pulses and the unit fields that come with them
    always @(posedge ref_clk) begin
        if (unit_valid === 1'b1) begin
            nq.push_back(unit_node);
            lq = unit_query;
            lc = unit_common;
            ld = unit_has_data;
            lw = unit_word;
        end
        if (cmd_error === 1'b1) n_err++;
        if (msg_end === 1'b1) n_end++;
        if (data_valid === 1'b1) dq.push_back(data_char);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // clear the log, send one message, let the answer pulses land
    task automatic go(input string s, input bit term);
        nq.delete();
        dq.delete();
        n_err = 0;
        n_end = 0;
        host.send(s, term);
        repeat (2) @(posedge ref_clk);
        #5;
    endtask
    task automatic s_query;
        go("vOlTaGe?", 1'b1);
        chk(nq.size(), 1);
        chk(nq[0], 12);
        chk(lq, 1);
        chk(n_end, 1);
        chk(tree_node, 0);
    endtask
    task automatic s_tree;
        go("meas:volt?;curr?", 1'b1);
        chk(nq.size(), 2);
        chk(nq[0], 25);
        chk(nq[1], 26);
        go("meas:volt?;:curr?", 1'b1);
        chk(nq[1], 13);
        go("STAT:OPER:COND?;ENAB 16", 1'b1);
        chk(nq[1], 19);
        chk(ld, 1);
        chk(dq.size(), 2);
        chk({dq[0], dq[1]}, 16'h3136);
    endtask
    task automatic s_eol;
        go("TRIG", 1'b0);
        chk(nq[0], 11);
        chk(n_end, 1);
    endtask
    task automatic s_forms;
        go("CURR:LEV:IMM", 1'b1);
        chk(nq[0], 28);
        go("curr:level:immediate", 1'b1);
        chk(nq[0], 28);
        go("stat:oper:enabl", 1'b1);
        chk(n_err, 1);
        chk(nq.size(), 0);
        go("func:mode", 1'b1);
        chk(nq[0], 24);
        go("MEASU;volt?", 1'b1);
        chk(n_err, 1);
        chk(nq[0], 12);
    endtask
    task automatic s_common;
        go("*RST", 1'b1);
        chk(nq.size(), 1);
        chk(lc, 1);
        chk(lq, 0);
        chk(lw[31:0], 32'h00525354);
        chk(lw[95:32] == 64'h0, 1);
        go("*idn?", 1'b1);
        chk(nq.size(), 1);
        chk(lc, 1);
        chk(lq, 1);
        chk(lw[31:0], 32'h0049444E);
    endtask
    task automatic s_roots;
        for (int i = 0; i < 11; i++) begin
            go(roots[i], 1'b1);
            chk(nq[0], i + 1);
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // reset, then every scenario in turn
    initial begin
        rst_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #5;
        rst_n = 1'b1;
        s_query();
        s_tree();
        s_eol();
        s_forms();
        s_common();
        s_roots();
        close_out();
    end
endmodule
